// ===== bench/pcr_checker.sv
// port-level assertions for the chopper and event flag block
module pcr_checker
  import pcr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pwm_a_i,
  input wire logic        pwm_b_i,
  input wire logic        pwm_a_o,
  input wire logic        pwm_b_o,
  input wire logic        module_irq_output_o,
  input wire logic        dma_req_o,
  input wire logic [1:0]  fine_edge_select_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // dma request rides on the interrupt pulse
  dma_same_a:
    assert property (dma_req_o == module_irq_output_o) else $error("dma request differs from irq pulse");
  // a pulse sets the flag, so no second pulse follows at once
  irq_single_a:
    assert property (module_irq_output_o |=> !module_irq_output_o) else $error("irq pulse repeated");
  // output can only be high where the pwm input was high
  gate_a_a:
    assert property (!pwm_a_i |=> !pwm_a_o) else $error("pwm a high without input");
  gate_b_a:
    assert property (!pwm_b_i |=> !pwm_b_o) else $error("pwm b high without input");
  // responses hold until taken
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("late write answer");
  // edge select moves only with a completed write
  edge_write_a:
    assert property ($changed(fine_edge_select_o) |-> s_axi_bvalid) else $error("edge select moved alone");

  // main scenarios reached
  cover property (module_irq_output_o);
  cover property (irq_o);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property (pwm_a_i && !pwm_a_o);
endmodule // pcr_checker

bind pcr_top pcr_checker u_chk (.*);

// ===== bench/tb.sv
// self-checking testbench of the chopper and event flag block
`include "pcr_params.svh"

module tb;
  import pcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i, nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        pwm_a_i, pwm_b_i, irq_event_i, ctr_zero_i, ctr_period_i;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pwm_a_o, pwm_b_o, module_irq_output_o, dma_req_o, fine_source_select_o, irq_o;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fine_edge_select_o;
  logic [7:0]  fine_compare_value_o;
  logic [33:0] exp_q[$];
  int          failures = 0;
  int          cmp_count = 0;
  int          pulses = 0;
  int          cyc = 0;

  pcr_top #(.HAS_FINE(1'b1)) DUT (.*);

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt();
    repeat (3) @(posedge clk_i);
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r = `PCR_BRESP_OKAY);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
    chk(34'(s_axi_bresp), 34'(r));
  endtask

  // one read, expectation noted for the monitor
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
  endtask

  // one-cycle pulse on event (0), zero (1) or period (2)
  task automatic pls(input int k);
    {ctr_period_i, ctr_zero_i, irq_event_i} <= 3'(1 << k);
    @(posedge clk_i);
    {ctr_period_i, ctr_zero_i, irq_event_i} <= 3'b000;
    wt();
  endtask

  // read monitor, pulse counter, random b input, timeout
  always @(posedge clk_i)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (module_irq_output_o === 1'b1)
      pulses++;
    pwm_b_i <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  // main sequence
  initial
  begin
    logic [15:0] v;
    int n;
    int r;
    logic p;
    {nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {pwm_a_i, irq_event_i, ctr_zero_i, ctr_period_i} = 4'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h0a25));
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // reset values, write-only reads and unmapped place
    rd(`PCR_OFF_CHOP_CTRL, 34'h0);
    rd(`PCR_OFF_FINE_CFG, 34'h0);
    wr(`PCR_OFF_FLAG_CLEAR, 16'hffff);
    rd(`PCR_OFF_FLAG_CLEAR, 34'h0);
    rd(`PCR_OFF_FLAG_FORCE, 34'h0);
    rd(12'h200, {`PCR_BRESP_SLVERR, 32'h0});
    wr(12'h200, 16'h0001, `PCR_BRESP_SLVERR);
    repeat (4)
    begin
      v = 16'($urandom);
      wr(`PCR_OFF_CHOP_CTRL, v);
      rd(`PCR_OFF_CHOP_CTRL, 34'(v & `PCR_CHOP_MASK));
    end
    // every edge and source code reaches the outputs
    for (int k = 0; k < 16; k++)
    begin
      v = {12'($urandom), 4'(k)};
      wr(`PCR_OFF_FINE_CFG, v);
      chk(34'(fine_edge_select_o), 34'(k & 3));
      chk(34'(fine_source_select_o), 34'((k >> 2) & 1));
      rd(`PCR_OFF_FINE_CFG, 34'(v & `PCR_FINE_MASK));
    end
    // shadow loads on zero, then on period
    wr(`PCR_OFF_FINE_CFG, 16'h0008);
    wr(`PCR_OFF_SHADOW_CMP, 16'h005a);
    pls(2);
    chk(34'(fine_compare_value_o), 34'h0);
    pls(1);
    chk(34'(fine_compare_value_o), 34'h5a);
    wr(`PCR_OFF_FINE_CFG, 16'h0000);
    wr(`PCR_OFF_SHADOW_CMP, 16'h0033);
    pls(1);
    chk(34'(fine_compare_value_o), 34'h5a);
    pls(2);
    chk(34'(fine_compare_value_o), 34'h33);
    // phase control mode: load select ignored
    wr(`PCR_OFF_FINE_CFG, 16'h000c);
    wr(`PCR_OFF_SHADOW_CMP, 16'h0011);
    pls(1);
    chk(34'(fine_compare_value_o), 34'h33);
    // forced flag with interrupt disabled: no pulse
    wr(`PCR_OFF_FLAG_FORCE, 16'h0001);
    wt();
    chk(34'(pulses), 34'd0);
    rd(`PCR_OFF_EVT_SELECT, 34'h2);
    wr(`PCR_OFF_FLAG_CLEAR, 16'h0001);
    rd(`PCR_OFF_EVT_SELECT, 34'h0);
    wr(`PCR_OFF_EVT_SELECT, 16'h0001);
    wr(`PCR_OFF_IRQ_MASK, 16'h0001);
    wr(`PCR_OFF_FLAG_FORCE, 16'h0001);
    wt();
    chk(34'(pulses), 34'd1);
    chk(34'(irq_o), 34'h1);
    wr(`PCR_OFF_FLAG_FORCE, 16'h0000);
    pls(0);
    wr(`PCR_OFF_FLAG_CLEAR, 16'h0000);
    wt();
    chk(34'(pulses), 34'd1);
    wr(`PCR_OFF_FLAG_CLEAR, 16'h0001);
    wt();
    chk(34'(pulses), 34'd2);
    wr(`PCR_OFF_FLAG_CLEAR, 16'h0001);
    pls(0);
    chk(34'(pulses), 34'd3);
    // mask gates the level, status clears by one
    wr(`PCR_OFF_IRQ_MASK, 16'h0000);
    chk(34'(irq_o), 34'h0);
    wr(`PCR_OFF_IRQ_MASK, 16'h0001);
    wr(`PCR_OFF_IRQ_STATUS, 16'h0001);
    wt();
    chk(34'(irq_o), 34'h0);
    // bypass passes the pwm level
    wr(`PCR_OFF_CHOP_CTRL, 16'h0700);
    pwm_a_i <= 1'b1;
    wt();
    chk(34'(pwm_a_o), 34'h1);
    pwm_a_i <= 1'b0;
    wt();
    // first pulse width with the carrier held low
    for (int k = 0; k < 3; k++)
    begin
      v = (k == 2) ? 16'($urandom % 16) : 16'(k * 15);
      wr(`PCR_OFF_CHOP_CTRL, {5'h00, 3'h7, 3'h0, v[3:0], 1'b1});
      pwm_a_i <= 1'b1;
      n = 0;
      repeat (150)
      begin
        @(posedge clk_i);
        n += int'(pwm_a_o === 1'b1);
      end
      chk(34'(n), 34'((v + 1) * 8));
      pwm_a_i <= 1'b0;
      wt();
      chk(34'(pwm_a_o), 34'h0);
    end
    // carrier: 3/8 duty, divide by 2, over eight periods
    wr(`PCR_OFF_CHOP_CTRL, {5'h00, 3'h2, 3'h1, 4'h0, 1'b1});
    pwm_a_i <= 1'b1;
    repeat (24) @(posedge clk_i);
    n = 0;
    r = 0;
    p = pwm_a_o;
    repeat (128)
    begin
      @(posedge clk_i);
      n += int'(pwm_a_o === 1'b1);
      r += int'(pwm_a_o === 1'b1 && p === 1'b0);
      p = pwm_a_o;
    end
    chk(34'(n), 34'd48);
    chk(34'(r), 34'd8);
    pwm_a_i <= 1'b0;
    wt();
    tally_and_finish();
  end
endmodule // tb

// ===== logic/pcr_params.svh
// offsets, field positions, reset values and timing counts of the chopper/event block
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// printed offsets are word indices: byte address is four times the index
`define PCR_OFF_FLAG_CLEAR   {2'b00, `PCR_IDX_FLAG_CLEAR, 2'b00}
`define PCR_OFF_FLAG_FORCE   {2'b00, `PCR_IDX_FLAG_FORCE, 2'b00}
`define PCR_OFF_CHOP_CTRL    {2'b00, `PCR_IDX_CHOP_CTRL, 2'b00}
`define PCR_OFF_FINE_CFG     {2'b00, `PCR_IDX_FINE_CFG, 2'b00}
`define PCR_OFF_IRQ_STATUS   12'h100
`define PCR_OFF_IRQ_MASK     12'h104
`define PCR_OFF_EVT_SELECT   12'h108
`define PCR_OFF_SHADOW_CMP   12'h10c
`define PCR_OFF_ACTIVE_CMP   12'h110

`define PCR_IDX_FLAG_CLEAR   8'h38
`define PCR_IDX_FLAG_FORCE   8'h3a
`define PCR_IDX_CHOP_CTRL    8'h3c
`define PCR_IDX_FINE_CFG     8'hc0

`define PCR_CHOP_MASK        16'h07ff
`define PCR_FINE_MASK        16'h000f
`define PCR_DUTY_RSVD        3'h7
`define PCR_OSHT_PRESCALE    3'h7
`define PCR_CHOP_RESET       16'h0000
`define PCR_FINE_RESET       16'h0000

`define PCR_BRESP_OKAY       2'b00
`define PCR_BRESP_SLVERR     2'b10

`endif

// ===== logic/pcr_pkg.sv
// types of the chopper/event block
package pcr_pkg;

  // chopper control field layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] carrier_duty;
    logic [2:0] carrier_divider;
    logic [3:0] first_pulse_width;
    logic       carrier_gate_on;
  } pcr_chop_type;

  // fine edge configuration field layout
  typedef struct packed {
    logic [11:0] rsvd;
    logic        fine_shadow_load_event;
    logic        fine_source_select;
    logic [1:0]  fine_edge_select;
  } pcr_fine_type;

  // chopper sequencing
  typedef enum logic [1:0] {
    PCR_IDLE,
    PCR_FIRST,
    PCR_SUSTAIN
  } pcr_chop_state_type;

  // interrupt status/mask bits
  typedef struct packed {
    logic shadow_loaded;
    logic irq_pulse;
  } pcr_events_type;

endpackage

// ===== logic/pcr_top.sv
// chopper, fine edge configuration and event flag registers behind an AXI4-Lite slave
// Behaviour
// - write one clears flag, reads zero
// - clearing flag re-arms DMA requests too
// - force sets flag, pulses if enabled
// - force zero ignored, reads zero
// - duty field gives (code+1)/8 high time, code 7 holds carrier low
// - divider field divides carrier by code+1
// - first pulse lasts code+1 sysclk/8 periods
// - gate bit zero bypasses chopper
// - fine register only when extension present
// - shadow load on period or zero
// - load select honoured only in duty mode
// - source bit picks compare or phase
// - edge field: off, rise, fall, both
// - no pulse while flag set, one pends
//
// Design decision made here: the AXI4-Lite register port.
`include "pcr_params.svh"

module pcr_top
  import pcr_pkg::*;
#(
  parameter bit HAS_FINE = 1'b1
)(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pwm_a_i,
  input  wire logic        pwm_b_i,
  input  wire logic        irq_event_i,
  input  wire logic        ctr_zero_i,
  input  wire logic        ctr_period_i,
  output      logic        pwm_a_o,
  output      logic        pwm_b_o,
  output      logic        module_irq_output_o,
  output      logic        dma_req_o,
  output      logic [1:0]  fine_edge_select_o,
  output      logic        fine_source_select_o,
  output      logic [7:0]  fine_compare_value_o,
  output      logic        irq_o
);

  // reset release through two flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ---- AXI4-Lite write side: address and data captured in any order
  logic        aw_held_q, aw_held_d;
  logic        w_held_q, w_held_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        wr_go;
  logic        wr_hit;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_go         = aw_held_q && w_held_q && !bvalid_q;

  // write decode
  always_comb
  begin
    case (awaddr_q)
      `PCR_OFF_FLAG_CLEAR, `PCR_OFF_FLAG_FORCE, `PCR_OFF_CHOP_CTRL,
      `PCR_OFF_IRQ_STATUS, `PCR_OFF_IRQ_MASK, `PCR_OFF_EVT_SELECT,
      `PCR_OFF_SHADOW_CMP: wr_hit = 1'b1;
      `PCR_OFF_FINE_CFG:   wr_hit = HAS_FINE;
      default:             wr_hit = 1'b0;
    endcase
  end

  // write channel next state
  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      awaddr_d  = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? `PCR_BRESP_OKAY : `PCR_BRESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
    end
  end

  // byte-lane merge of write data into 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  logic wr_clear, wr_force, wr_chop, wr_fine, wr_stat, wr_mask, wr_sel, wr_shadow;
  assign wr_clear  = wr_go && awaddr_q == `PCR_OFF_FLAG_CLEAR && wstrb_q[0] && wdata_q[0];
  assign wr_force  = wr_go && awaddr_q == `PCR_OFF_FLAG_FORCE && wstrb_q[0] && wdata_q[0];
  assign wr_chop   = wr_go && awaddr_q == `PCR_OFF_CHOP_CTRL;
  assign wr_fine   = wr_go && awaddr_q == `PCR_OFF_FINE_CFG && HAS_FINE;
  assign wr_stat   = wr_go && awaddr_q == `PCR_OFF_IRQ_STATUS && wstrb_q[0];
  assign wr_mask   = wr_go && awaddr_q == `PCR_OFF_IRQ_MASK && wstrb_q[0];
  assign wr_sel    = wr_go && awaddr_q == `PCR_OFF_EVT_SELECT && wstrb_q[0];
  assign wr_shadow = wr_go && awaddr_q == `PCR_OFF_SHADOW_CMP && wstrb_q[0];

  // ---- configuration registers
  logic [15:0]    chop_q, chop_d;
  logic [15:0]    fine_q, fine_d;
  logic           irq_en_q, irq_en_d;
  logic [1:0]     mask_q, mask_d;
  logic [7:0]     shadow_q, shadow_d;
  pcr_chop_type   chop;
  pcr_fine_type   fine;
  assign chop = pcr_chop_type'(chop_q);
  assign fine = pcr_fine_type'(fine_q);

  always_comb
  begin
    chop_d   = chop_q;
    fine_d   = fine_q;
    irq_en_d = irq_en_q;
    mask_d   = mask_q;
    shadow_d = shadow_q;
    if (wr_chop)
      chop_d = merge16(chop_q, wdata_q, wstrb_q) & `PCR_CHOP_MASK;
    if (wr_fine)
      fine_d = merge16(fine_q, wdata_q, wstrb_q) & `PCR_FINE_MASK;
    if (wr_sel)
      irq_en_d = wdata_q[0];
    if (wr_mask)
      mask_d = wdata_q[1:0];
    if (wr_shadow)
      shadow_d = wdata_q[7:0];
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chop_q   <= `PCR_CHOP_RESET;
      fine_q   <= `PCR_FINE_RESET;
      irq_en_q <= 1'b0;
      mask_q   <= 2'b00;
      shadow_q <= 8'h00;
    end
    else
    begin
      chop_q   <= chop_d;
      fine_q   <= fine_d;
      irq_en_q <= irq_en_d;
      mask_q   <= mask_d;
      shadow_q <= shadow_d;
    end
  end

  // ---- latched event flag, pending event, pulse generation
  logic flag_q, flag_d, pend_q, pend_d, pulse_q, pulse_d;
  logic active_q, active_d;
  logic load_evt;
  logic fire;
  always_comb
  begin
    flag_d  = flag_q;
    pend_d  = pend_q;
    pulse_d = 1'b0;
    fire    = 1'b0;
    if (wr_clear)
      flag_d = 1'b0;
    if (irq_event_i && irq_en_q)
    begin
      if (flag_d)
        pend_d = 1'b1;
      else
        fire = 1'b1;
    end
    else if (pend_q && !flag_d)
    begin
      pend_d = 1'b0;
      fire   = 1'b1;
    end
    if (fire)
    begin
      flag_d  = 1'b1;
      pulse_d = 1'b1;
    end
    if (wr_force)
    begin
      flag_d  = 1'b1;
      pulse_d = pulse_d | (irq_en_q && !flag_q);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q  <= 1'b0;
      pend_q  <= 1'b0;
      pulse_q <= 1'b0;
    end
    else
    begin
      flag_q  <= flag_d;
      pend_q  <= pend_d;
      pulse_q <= pulse_d;
    end
  end
  assign module_irq_output_o = pulse_q;
  assign dma_req_o           = pulse_q;

  // ---- fine edge shadow load
  always_comb
  begin
    active_d = active_q;
    load_evt = 1'b0;
    if (!fine.fine_source_select)
      load_evt = fine.fine_shadow_load_event ? ctr_zero_i : ctr_period_i;
    if (load_evt)
      active_d = 1'b1;
  end
  logic [7:0] fine_cmp_q, fine_cmp_d;
  assign fine_cmp_d = load_evt ? shadow_q : fine_cmp_q;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fine_cmp_q <= 8'h00;
      active_q   <= 1'b0;
    end
    else
    begin
      fine_cmp_q <= fine_cmp_d;
      active_q   <= active_d;
    end
  end
  assign fine_compare_value_o = fine_cmp_q;
  assign fine_edge_select_o   = HAS_FINE ? fine.fine_edge_select : 2'b00;
  assign fine_source_select_o = HAS_FINE ? fine.fine_source_select : 1'b0;

  // ---- sticky status, mask, interrupt line
  logic [1:0] stat_q, stat_d;
  pcr_events_type evts;
  assign evts = '{shadow_loaded: load_evt, irq_pulse: pulse_q};
  always_comb
  begin
    stat_d = stat_q;
    if (wr_stat)
      stat_d = stat_q & ~wdata_q[1:0];
    stat_d = stat_d | evts; // set wins over clear
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= 2'b00;
    else
      stat_q <= stat_d;
  end
  assign irq_o = |(stat_q & mask_q);

  // ---- chopper: carrier shared, first pulse per channel
  logic [2:0] div_q, div_d;
  logic [2:0] phase_q, phase_d;
  logic       carrier;
  logic [1:0] pwm_in;
  assign pwm_in = {pwm_b_i, pwm_a_i};

  // divided clock ticks then an 8-phase carrier
  always_comb
  begin
    div_d   = div_q;
    phase_d = phase_q;
    if (div_q >= chop.carrier_divider)
    begin
      div_d   = 3'h0;
      phase_d = phase_q + 3'h1;
    end
    else
      div_d = div_q + 3'h1;
    carrier = (chop.carrier_duty != `PCR_DUTY_RSVD) && (phase_q <= chop.carrier_duty);
  end

  // carrier divider registers
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q   <= 3'h0;
      phase_q <= 3'h0;
    end
    else
    begin
      div_q   <= div_d;
      phase_q <= phase_d;
    end
  end

  // own sequencer per channel, so a pulse on one never skips the other's first pulse
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      pcr_chop_state_type st_q, st_d;
      logic [2:0]         osht_pre_q, osht_pre_d;
      logic [3:0]         osht_cnt_q, osht_cnt_d;
      logic               chopped;
      logic               out_d, out_q;

      // first pulse sequencing per pwm high phase
      always_comb
      begin
        st_d       = st_q;
        osht_pre_d = osht_pre_q;
        osht_cnt_d = osht_cnt_q;
        case (st_q)
          PCR_IDLE:
            if (pwm_in[ch])
            begin
              st_d       = PCR_FIRST;
              osht_pre_d = 3'h0;
              osht_cnt_d = chop.first_pulse_width;
            end
          PCR_FIRST:
            if (!pwm_in[ch])
              st_d = PCR_IDLE;
            else if (osht_pre_q == `PCR_OSHT_PRESCALE)
            begin
              osht_pre_d = 3'h0;
              if (osht_cnt_q == 4'h0)
                st_d = PCR_SUSTAIN;
              else
                osht_cnt_d = osht_cnt_q - 4'h1;
            end
            else
              osht_pre_d = osht_pre_q + 3'h1;
          PCR_SUSTAIN:
            if (!pwm_in[ch])
              st_d = PCR_IDLE;
          default:
            st_d = PCR_IDLE;
        endcase
      end

      // output gating
      assign chopped = (st_q == PCR_FIRST) | ((st_q == PCR_SUSTAIN) & carrier);
      assign out_d   = chop.carrier_gate_on ? (pwm_in[ch] & chopped) : pwm_in[ch];

      always_ff @(posedge clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          st_q       <= PCR_IDLE;
          osht_pre_q <= 3'h0;
          osht_cnt_q <= 4'h0;
          out_q      <= 1'b0;
        end
        else
        begin
          st_q       <= st_d;
          osht_pre_q <= osht_pre_d;
          osht_cnt_q <= osht_cnt_d;
          out_q      <= out_d;
        end
      end
    end
  endgenerate
  assign pwm_a_o = g_chan[0].out_q;
  assign pwm_b_o = g_chan[1].out_q;

  // ---- AXI4-Lite read side, one cycle to answer
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [11:0] ra;
  assign s_axi_arready = !rvalid_q;
  assign ra            = {s_axi_araddr[11:2], 2'b00};
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = `PCR_BRESP_OKAY;
      case (ra)
        `PCR_OFF_FLAG_CLEAR: rdata_d = 32'h0000_0000;
        `PCR_OFF_FLAG_FORCE: rdata_d = 32'h0000_0000;
        `PCR_OFF_CHOP_CTRL:  rdata_d = {16'h0000, chop_q};
        `PCR_OFF_FINE_CFG:
        begin
          rdata_d = HAS_FINE ? {16'h0000, fine_q} : 32'h0000_0000;
          rresp_d = HAS_FINE ? `PCR_BRESP_OKAY : `PCR_BRESP_SLVERR;
        end
        `PCR_OFF_IRQ_STATUS: rdata_d = {29'h0000_0000, pend_q, stat_q};
        `PCR_OFF_IRQ_MASK:   rdata_d = {30'h0000_0000, mask_q};
        `PCR_OFF_EVT_SELECT: rdata_d = {30'h0000_0000, flag_q, irq_en_q};
        `PCR_OFF_SHADOW_CMP: rdata_d = {24'h00_0000, shadow_q};
        `PCR_OFF_ACTIVE_CMP: rdata_d = {23'h00_0000, active_q, fine_cmp_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = `PCR_BRESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'b00;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule // pcr_top
